// ### verilog/port_c_alternate_function_mux.v
/*
 * Port C alternate-function multiplexer: merges the port direction, value
 * and pull-up registers with peripheral overrides and routes pin inputs
 * back to the timers, CAN, SPI, power stage and interrupt logic.
 * Assumes the pad ring resolves the pin level from out/oe and the pull-up
 * request; pin inputs are asynchronous and are synchronised here.
 * Assumes the analog blocks take the pads directly, so a disabled digital
 * input only blanks what the timers, CAN, SPI select, power stage and port read see.
 * Assumes software keeps analog pins as inputs with their pull-ups off.
 * Assumes pin pulses shorter than two clock cycles may be missed.
 */
// What this block does
// - pin1 drives timer1 compare B when direction output
// - pin1 carries timer1 compare B PWM output
// - SPI slave on alternate set forces select input
// - slave SPI active only while select low
// - SPI master leaves select direction to register
// - forced-input select keeps pull-up via value bit
// - pin0 supplies interrupt 3, enable overrides input
// - pin3 feeds timer1 alternate capture input
// - pin3 feeds timer1 external count source
// - pin2 feeds timer0 external count source
`timescale 1ns/1ns
`include "port_c_mux_defs.vh"

module port_c_alternate_function_mux #(
    parameter WIDTH = `PC_WIDTH
) (
    input  wire             clk_sys_in,
    input  wire             srst_in,
    // port registers
    input  wire [WIDTH-1:0] port_direction_in,
    input  wire [WIDTH-1:0] port_value_in,
    input  wire             pullup_disable_in,
    input  wire             slave_select_direction_bit_in,
    input  wire             slave_select_pullup_value_bit_in,
    // peripheral controls
    input  wire             timer1_compare_b_output_in,
    input  wire             timer1_compare_b_output_enable_in,
    input  wire             spi_enable_in,
    input  wire             spi_master_in,
    input  wire             spi_alt_pins_in,
    input  wire             external_interrupt_three_enable_in,
    input  wire             dac_output_enable_in,
    input  wire             power_stage_output_1a_enable_in,
    input  wire             power_stage_output_1a_value_in,
    input  wire [WIDTH-1:0] analog_input_disable_in,
    // pins
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] pin_out,
    output reg  [WIDTH-1:0] pin_oe_n_out,
    output reg  [WIDTH-1:0] pin_pullup_out,
    // routed inputs
    output reg  [WIDTH-1:0] port_read_out,
    output reg              external_interrupt_three_out,
    output reg              timer1_alt_capture_input_out,
    output reg              timer1_count_input_out,
    output reg              timer0_count_input_out,
    output reg              can_receive_pin_out,
    output reg              power_stage_digital_input_1_out,
    output reg              spi_slave_select_n_out,
    output reg              spi_slave_active_out
);

    // ****************************************
    // override function
    // ****************************************
    function ovr;
        input oe;
        input ov;
        input reg_val;
        begin
            ovr = oe ? ov : reg_val;
        end
    endfunction

    // ****************************************
    // pull-up function
    // ****************************************
    function pullup_term;
        input dir;
        input val;
        input pud;
        begin
            pullup_term = ~dir & val & ~pud;
        end
    endfunction

    // ****************************************
    // pin input synchroniser
    // ****************************************
    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;
    reg [WIDTH-1:0] pin_clean_q;

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            s1_q <= `PC_RESET_BYTE;
        end else begin
            s1_q <= pin_in;
        end
    end

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            s2_q <= `PC_RESET_BYTE;
        end else begin
            s2_q <= s1_q;
        end
    end

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            s3_q <= `PC_RESET_BYTE;
        end else begin
            s3_q <= s2_q;
        end
    end

    // change accepted only when stages two and three agree
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            pin_clean_q <= `PC_RESET_BYTE;
        end else begin
            pin_clean_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_clean_q);
        end
    end

    // ****************************************
    // override terms
    // ****************************************
    // alternate slave: select pin is forced to input
    wire spi_slave_alt = spi_enable_in & ~spi_master_in & spi_alt_pins_in;

    reg [WIDTH-1:0] dd_d;
    reg [WIDTH-1:0] pv_d;
    reg [WIDTH-1:0] pu_d;
    reg [WIDTH-1:0] die_d;
    integer         i;

    always @* begin
        // register defaults, every pin
        for (i = 0; i < WIDTH; i = i + 1) begin
            dd_d[i]  = port_direction_in[i];
            pv_d[i]  = port_value_in[i];
            pu_d[i]  = pullup_term(port_direction_in[i], port_value_in[i], pullup_disable_in);
            die_d[i] = ovr(analog_input_disable_in[i], 1'h0, 1'h1);
        end

        // pin 0: power stage output; interrupt 3 keeps the input on
        dd_d[`PC_PIN_EXT_EXTERNAL_INTERRUPT_THREE]  = ovr(power_stage_output_1a_enable_in, 1'h1,
                                      port_direction_in[`PC_PIN_EXT_EXTERNAL_INTERRUPT_THREE]);
        pv_d[`PC_PIN_EXT_EXTERNAL_INTERRUPT_THREE]  = ovr(power_stage_output_1a_enable_in, power_stage_output_1a_value_in,
                                      port_value_in[`PC_PIN_EXT_EXTERNAL_INTERRUPT_THREE]);
        pu_d[`PC_PIN_EXT_EXTERNAL_INTERRUPT_THREE]  = pu_d[`PC_PIN_EXT_EXTERNAL_INTERRUPT_THREE] & ~power_stage_output_1a_enable_in;
        die_d[`PC_PIN_EXT_EXTERNAL_INTERRUPT_THREE] = ovr(external_interrupt_three_enable_in, external_interrupt_three_enable_in,
                                      1'h1);

        // pin 1: compare B rides on the value, drive needs the direction bit
        dd_d[`PC_PIN_SLAVE_SEL] = spi_slave_alt ? 1'h0 : slave_select_direction_bit_in;
        pv_d[`PC_PIN_SLAVE_SEL] = ovr(timer1_compare_b_output_enable_in, timer1_compare_b_output_in,
                                      port_value_in[`PC_PIN_SLAVE_SEL]);
        // forced-input select still honours its own pull-up bit
        pu_d[`PC_PIN_SLAVE_SEL] = spi_slave_alt ? pullup_term(1'h0, slave_select_pullup_value_bit_in,
                                                              pullup_disable_in)
                                                : pu_d[`PC_PIN_SLAVE_SEL];

        // pins 2 to 6 keep the register values

        // pin 7: DAC owns the pin, digital input off
        dd_d[`PC_PIN_DAC]  = ovr(dac_output_enable_in, 1'h0, port_direction_in[`PC_PIN_DAC]);
        pu_d[`PC_PIN_DAC]  = pu_d[`PC_PIN_DAC] & ~dac_output_enable_in;
        die_d[`PC_PIN_DAC] = ovr(dac_output_enable_in, 1'h0, 1'h1);
    end

    // ****************************************
    // gated pin read and slave select
    // ****************************************
    wire [WIDTH-1:0] din = pin_clean_q & die_d;

    // routed taps; only interrupt 3 bypasses the gate
    wire             pin0_level = pin_clean_q[`PC_PIN_EXT_EXTERNAL_INTERRUPT_THREE];
    wire             pin1_level = din[`PC_PIN_SLAVE_SEL];
    wire             pin2_level = din[`PC_PIN_T0_CAN_TX];
    wire             pin3_level = din[`PC_PIN_T1_CAN_RX];
    reg              ss_level_d;
    reg              ss_active_d;

    always @* begin
        ss_level_d  = 1'h1;
        ss_active_d = 1'h0;
        if (spi_slave_alt) begin
            ss_level_d  = pin1_level;
            ss_active_d = ~pin1_level;
        end
    end

    // ****************************************
    // registered pin drive
    // ****************************************
    // registered: one cycle latency traded for glitch-free pads
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            pin_out <= `PC_RESET_BYTE;
        end else begin
            pin_out <= pv_d;
        end
    end

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            pin_oe_n_out <= {WIDTH{1'h1}};
        end else begin
            pin_oe_n_out <= ~dd_d;
        end
    end

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            pin_pullup_out <= `PC_RESET_BYTE;
        end else begin
            pin_pullup_out <= pu_d;
        end
    end

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            port_read_out <= `PC_RESET_BYTE;
        end else begin
            port_read_out <= din;
        end
    end

    // ****************************************
    // registered routed inputs
    // ****************************************
    // interrupt sees the pin even with digital input overridden
    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            external_interrupt_three_out <= 1'h0;
        end else begin
            external_interrupt_three_out <= pin0_level;
        end
    end

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            timer1_alt_capture_input_out <= 1'h0;
        end else begin
            timer1_alt_capture_input_out <= pin3_level;
        end
    end

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            timer1_count_input_out <= 1'h0;
        end else begin
            timer1_count_input_out <= pin3_level;
        end
    end

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            can_receive_pin_out <= 1'h0;
        end else begin
            can_receive_pin_out <= pin3_level;
        end
    end

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            timer0_count_input_out <= 1'h0;
        end else begin
            timer0_count_input_out <= pin2_level;
        end
    end

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            power_stage_digital_input_1_out <= 1'h0;
        end else begin
            power_stage_digital_input_1_out <= pin1_level;
        end
    end

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            spi_slave_select_n_out <= 1'h1;
        end else begin
            spi_slave_select_n_out <= ss_level_d;
        end
    end

    always @(posedge clk_sys_in) begin
        if (srst_in) begin
            spi_slave_active_out <= 1'h0;
        end else begin
            spi_slave_active_out <= ss_active_d;
        end
    end

endmodule // port_c_alternate_function_mux

// ### verilog/port_c_mux_defs.vh
/*
 * Constants for the port C alternate-function multiplexer: pin positions,
 * reset values and synchroniser depth.
 * Assumes it is included by bare name from the design file.
 */
`ifndef PORT_C_MUX_DEFS_VH
`define PORT_C_MUX_DEFS_VH

`define PC_WIDTH          8
`define PC_PIN_EXT_EXTERNAL_INTERRUPT_THREE   0
`define PC_PIN_SLAVE_SEL  1
`define PC_PIN_T0_CAN_TX  2
`define PC_PIN_T1_CAN_RX  3
`define PC_PIN_DAC        7
`define PC_RESET_BYTE     8'h00
`define PC_DIE_RESET      8'hff
`define PC_SYNC_STAGES    3

`endif

// ### test/port_c_mux_sva.sv
/* assertions on the port c mux ports; assumes one clock and a sync reset */
`timescale 1ns/1ns
module port_c_mux_sva #(parameter WIDTH = 8) (
    input wire clk_sys_in, srst_in, pullup_disable_in, slave_select_direction_bit_in,
    input wire slave_select_pullup_value_bit_in, timer1_compare_b_output_in, timer1_compare_b_output_enable_in,
    input wire spi_enable_in, spi_master_in, spi_alt_pins_in, dac_output_enable_in,
    input wire power_stage_output_1a_enable_in, power_stage_output_1a_value_in, spi_slave_active_out,
    input wire external_interrupt_three_out, timer1_count_input_out, timer1_alt_capture_input_out,
    input wire timer0_count_input_out, input wire [WIDTH-1:0] pin_in, pin_out, pin_oe_n_out, pin_pullup_out
);
    wire alt_slave = spi_enable_in & ~spi_master_in & spi_alt_pins_in;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    a_pin1_drive: assert property (!pin_oe_n_out[1] |-> $past(slave_select_direction_bit_in & ~alt_slave))
        else $error("pin1 driven");
    a_cmpb_value: assert property (timer1_compare_b_output_enable_in && slave_select_direction_bit_in && !alt_slave
        |=> pin_out[1] == $past(timer1_compare_b_output_in)) else $error("compare b");
    a_master_dir: assert property (spi_enable_in && spi_master_in
        |=> pin_oe_n_out[1] == !$past(slave_select_direction_bit_in)) else $error("master dir");
    a_select_pullup: assert property (alt_slave
        |=> pin_pullup_out[1] == $past(slave_select_pullup_value_bit_in & ~pullup_disable_in)) else $error("ss pu");
    a_slave_active: assert property ((alt_slave && !pin_in[1])[*7] |=> spi_slave_active_out)
        else $error("slave active");
    a_external_interrupt_three_route: assert property ($stable(pin_in[0])[*7] |=> external_interrupt_three_out == $past(pin_in[0]))
        else $error("external_interrupt_three");
    a_pin3_route: assert property ($stable(pin_in[3])[*7] |=> {timer1_count_input_out,
        timer1_alt_capture_input_out} == {2{$past(pin_in[3])}}) else $error("pin3");
    a_pin2_route: assert property ($stable(pin_in[2])[*7] |=> timer0_count_input_out == $past(pin_in[2]))
        else $error("pin2");
    a_dac_pin7: assert property (dac_output_enable_in |=> pin_oe_n_out[7] && !pin_pullup_out[7])
        else $error("dac pin7");
    a_power_pin0: assert property (power_stage_output_1a_enable_in
        |=> !pin_oe_n_out[0] && pin_out[0] == $past(power_stage_output_1a_value_in)) else $error("pin0");
    c_slave: cover property (alt_slave && spi_slave_active_out);
    c_power: cover property (power_stage_output_1a_enable_in);
    c_dac: cover property (dac_output_enable_in);
endmodule // port_c_mux_sva
bind port_c_alternate_function_mux port_c_mux_sva #(.WIDTH(WIDTH)) u_sva (.*);

// ### test/port_c_far_side.sv
/* circuits on the port c pins; assumes device drive wins over the outside */
`timescale 1ns/1ns
module port_c_far_side (
    input  wire       clk_in,
    input  wire [7:0] drive_in,
    input  wire [7:0] oe_n_in,
    input  wire [7:0] pullup_in,
    input  wire [7:0] ext_en_in,
    input  wire [7:0] ext_val_in,
    output wire [7:0] level_out
);
    reg [7:0] float_q = 8'h55;
    // a floating pin keeps changing so it never passes for a settled level
    always @(posedge clk_in) float_q <= ~float_q;
    assign level_out = (~oe_n_in & drive_in) | (oe_n_in & ext_en_in & ext_val_in)
                     | (oe_n_in & ~ext_en_in & (pullup_in | float_q));
endmodule // port_c_far_side

// ### test/port_c_alternate_function_mux_tb.sv
/* random bench for the port c mux; assumes outputs settle within 8 cycles */
`timescale 1ns/1ns
module port_c_alternate_function_mux_tb;
    reg clk_sys_in = 0, srst_in = 1, pud = 0, ssd = 0, ssp = 0, cmp = 0, cmp_en = 0, spe = 0, mst = 0, alp = 0;
    reg ie3 = 0, dac = 0, pse = 0, psv = 0, alt;
    reg [7:0] dir = 0, val = 0, aid = 0, ext_en = 0, ext_val = 0, e_oe_n, e_out, e_pu, e_lvl, e_rd, known;
    reg [31:0] seed = 32'd75480, r;
    wire [7:0] lvl, p_out, p_oe_n, p_pu, p_rd;
    wire i3, t1c, t1k, t0k, crx, ss_n, act;
    integer num_errors = 0, n_tests = 0, k;
    port_c_alternate_function_mux u_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .port_direction_in(dir),
        .port_value_in(val), .pullup_disable_in(pud), .slave_select_direction_bit_in(ssd),
        .slave_select_pullup_value_bit_in(ssp), .timer1_compare_b_output_in(cmp),
        .timer1_compare_b_output_enable_in(cmp_en), .spi_enable_in(spe), .spi_master_in(mst),
        .spi_alt_pins_in(alp), .external_interrupt_three_enable_in(ie3), .dac_output_enable_in(dac),
        .power_stage_output_1a_enable_in(pse), .power_stage_output_1a_value_in(psv),
        .analog_input_disable_in(aid), .pin_in(lvl), .pin_out(p_out), .pin_oe_n_out(p_oe_n),
        .pin_pullup_out(p_pu), .port_read_out(p_rd), .external_interrupt_three_out(i3),
        .timer1_alt_capture_input_out(t1c), .timer1_count_input_out(t1k), .timer0_count_input_out(t0k),
        .can_receive_pin_out(crx), .power_stage_digital_input_1_out(), .spi_slave_select_n_out(ss_n),
        .spi_slave_active_out(act));
    port_c_far_side u_far (.clk_in(clk_sys_in), .drive_in(p_out), .oe_n_in(p_oe_n), .pullup_in(p_pu),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));
    function automatic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task check(input [7:0] seen, input [7:0] exp, input [8*8-1:0] what);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR %0s expected %h seen %h", what, exp, seen);
        end
    endtask
    task conclude;
        if (num_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #200000 num_errors = num_errors + 1;
        conclude;
    end
    initial begin
        repeat (12) @(negedge clk_sys_in);
        check(p_oe_n, 8'hff, "rst_oe");
        srst_in = 0;
        for (k = 0; k < 300; k = k + 1) begin
            r = rnd();
            {dir, val, pud, ssd, ssp, cmp, cmp_en, spe, mst, alp, ie3, dac, pse, psv} = r[27:0];
            r = rnd();
            {aid, ext_en, ext_val} = {r[23:16] & 8'hf1, r[15:8] | 8'h0d, r[7:0]};
            // alternate slave corner every fourth round; every sixteenth, pull-up alone holds select high
            if (k % 4 == 0) {spe, mst, alp} = 3'b101;
            if (k % 16 == 0) {ssp, pud, ext_en[1]} = 3'b100;
            if (dac) {dir[7], val[7]} = 2'b00;
            repeat (8) @(negedge clk_sys_in);
            alt = spe & ~mst & alp;
            e_oe_n = ~dir;
            e_oe_n[1] = ~(ssd & ~alt);
            e_oe_n[0] = e_oe_n[0] & ~pse;
            e_oe_n[7] = e_oe_n[7] | dac;
            e_out = val;
            if (cmp_en) e_out[1] = cmp;
            if (pse) e_out[0] = psv;
            e_pu = ~dir & val & {8{~pud}} & {~dac, 5'h1f, 1'b0, ~pse};
            e_pu[1] = alt ? (ssp & ~pud) : (~dir[1] & val[1] & ~pud);
            e_lvl = (~e_oe_n & e_out) | (e_oe_n & ext_en & ext_val) | (e_oe_n & ~ext_en & e_pu);
            known = ~e_oe_n | ext_en | e_pu;
            e_rd = e_lvl & {~dac, ~aid[6:1], 1'b1};
            check(p_oe_n, e_oe_n, "oe_n");
            check(p_out & ~e_oe_n, e_out & ~e_oe_n, "out");
            check(p_pu, e_pu, "pullup");
            check(p_rd & known, e_rd & known, "read");
            check({i3, t1c, t1k, crx, t0k}, {e_lvl[0], {3{e_lvl[3]}}, e_lvl[2]}, "routed");
            if (known[1]) check({act, ss_n}, alt ? {~e_lvl[1], e_lvl[1]} : 2'b01, "select");
        end
        conclude;
    end
endmodule // port_c_alternate_function_mux_tb
